// File: hw/motor_spi_controller.sv
// controller end of the motor driver serial link, Avalon-MM slave
`default_nettype none
module motor_spi_controller
    import motor_spi_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    motor_spi_if.controller  link,
    input  wire logic [10:0] address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    output logic [31:0]      readdata,
    output logic             waitrequest
);
    typedef enum {H_IDLE, H_LEAD, H_HIGH, H_LOW, H_TAIL, H_GAP} hstate_e;

    hstate_e            state;
    logic [7:0]         tx_mem [MAX_BYTES];
    logic [7:0]         rx_mem [MAX_BYTES];
    logic [7:0]         len;
    logic               busy;
    logic               done;
    logic [HBITS_W-1:0] bit_no;
    logic [7:0]         rx_sr;
    logic [TICK_W-1:0]  tick;
    logic               sdo_s;

    pin_sync #(.RST_VAL(1'b1)) u_sdo (
        .clk     (clk),
        .sys_rst (sys_rst),
        .pin     (link.sdo_line),
        .level   (sdo_s)
    );

    wire take = (read || write) && !waitrequest;
    wire [6:0] idx = address[8:2];
    wire hit_ctrl = address == OFS_CTRL;
    wire hit_stat = address == OFS_STATUS;
    wire hit_sleep = address == OFS_SLEEP;
    wire hit_tx = address[10:9] == REGION_TX;
    wire hit_rx = address[10:9] == REGION_RX;
    wire [7:0] new_len = writedata[7:0];
    wire len_ok = new_len != 8'h00 && {1'b0, new_len} <= 9'(MAX_BYTES);
    wire start = take && write && hit_ctrl && !busy && len_ok &&
        writedata[CTRL_START_BIT];
    wire [31:0] rd_mux =
        hit_ctrl ? {24'h000000, len} :
        hit_stat ? {30'h00000000, done, busy} :
        hit_sleep ? {31'h00000000, link.sleep_request_n} :
        hit_tx ? {24'h000000, tx_mem[idx]} :
        hit_rx ? {24'h000000, rx_mem[idx]} : 32'h00000000;
    wire tick_end = tick == '0;
    wire [HBITS_W:0] nbits = {len, 3'h0};
    wire last_bit = {1'b0, bit_no} == nbits - (HBITS_W + 1)'(1);
    wire [7:0] tx_cur = tx_mem[bit_no[HBITS_W-1:3]];
    wire [7:0] rx_next = {rx_sr[6:0], sdo_s};
    localparam logic [TICK_W-1:0] HALF = TICK_W'(SCLK_HALF_CYC - 1);
    localparam logic [TICK_W-1:0] GAP = TICK_W'(CS_GAP_CYC - 1);

    // one wait cycle, then answer
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            waitrequest <= 1'b1;
            readdata <= 32'h00000000;
        end else begin
            waitrequest <= !((read || write) && waitrequest);
            if (read && waitrequest) begin
                readdata <= rd_mux;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            len <= LEN_RESET;
            link.sleep_request_n <= SLEEP_N_RESET;
        end else if (take && write) begin
            if (hit_ctrl && !busy) begin
                len <= new_len;
            end
            if (hit_sleep) begin
                link.sleep_request_n <= writedata[0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (take && write && hit_tx) begin
            tx_mem[idx] <= writedata[7:0];
        end
    end

    // serial engine; leading and trailing half periods keep clock low
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= H_IDLE;
            busy <= 1'b0;
            done <= 1'b0;
            bit_no <= '0;
            rx_sr <= 8'h00;
            tick <= '0;
            link.sclk <= 1'b0;
            link.chip_select_n <= 1'b1;
            link.sdi <= 1'b0;
        end else begin
            if (!tick_end) begin
                tick <= tick - TICK_W'(1);
            end
            unique case (state)
                H_IDLE: begin
                    if (start) begin
                        busy <= 1'b1;
                        done <= 1'b0;
                        bit_no <= '0;
                        tick <= HALF;
                        link.chip_select_n <= 1'b0;
                        link.sdi <= tx_mem[0][7];
                        state <= H_LEAD;
                    end
                end
                H_LEAD, H_LOW: begin
                    if (tick_end) begin
                        link.sclk <= 1'b1;
                        link.sdi <= tx_cur[~bit_no[2:0]];
                        tick <= HALF;
                        state <= H_HIGH;
                    end
                end
                H_HIGH: begin
                    if (tick_end) begin
                        link.sclk <= 1'b0;
                        rx_sr <= rx_next;
                        if (bit_no[2:0] == 3'h7) begin
                            rx_mem[bit_no[HBITS_W-1:3]] <= rx_next;
                        end
                        bit_no <= bit_no + HBITS_W'(1);
                        tick <= HALF;
                        state <= last_bit ? H_TAIL : H_LOW;
                    end
                end
                H_TAIL: begin
                    if (tick_end) begin
                        link.chip_select_n <= 1'b1;
                        tick <= GAP;
                        state <= H_GAP;
                    end
                end
                H_GAP: begin
                    if (tick_end) begin
                        busy <= 1'b0;
                        done <= 1'b1;
                        state <= H_IDLE;
                    end
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// File: hw/motor_spi_target.sv
// device end of the motor driver serial port with daisy chain
//
// Notes on behaviour
// - input frame: command byte then data byte
// - output: status byte then report byte
// - serial clock low at select edges
// - select high 500 ns between frames
// - select high: ignore inputs, release output
// - exactly 16, or 16 per device plus 16
// - wrong count: error flag, write dropped
// - launch on rise, sample on fall
// - most significant bit first both ways
// - command: type, read/write, six address bits
// - low byte is write data
// - status byte top two bits forced high
// - six fault flags in fixed order
// - report: register content before any write
// - chain input: headers, addresses, then data
// - chain output: statuses, headers, then reports
// - six-bit device count, 63 at most
// - header clear-fault clears on select rise
// - header bytes start with one, zero
// - position from status bytes before header
// - sleep low disables the port
// - controller writes only mapped addresses
//
// Chosen here: the register addresses and the Avalon-MM register port.
`default_nettype none
module motor_spi_target
    import motor_spi_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       sys_rst,
    motor_spi_if.target     link,
    input  wire logic [5:0] fault_in,
    output logic [5:0]      faults,
    output logic            frame_error,
    output logic            wr_valid,
    output logic [5:0]      wr_addr,
    output logic [7:0]      wr_data
);
    typedef enum {
        PH_FIRST, PH_STD, PH_STATUS, PH_CHAIN_HEADER_SECOND, PH_BODY, PH_DONE
    } phase_e;

    logic               sclk_s;
    logic               cs_n_s;
    logic               sdi_s;
    logic               awake_s;
    logic               sclk_d;
    logic               cs_n_d;
    phase_e             phase;
    logic [FBITS_W-1:0] fbits;
    logic [7:0]         rx_sr;
    logic [7:0]         tx_byte;
    logic [5:0]         pos;
    logic [5:0]         n_dev;
    logic [6:0]         body_idx;
    logic [7:0]         cmd;
    logic [7:0]         data;
    logic               have_cmd;
    logic               have_data;
    logic               chain;
    logic               clr_req;
    logic               in_frame;
    logic               sclk_bad;
    logic [7:0]         mem [64];

    pin_sync u_sclk (
        .clk     (clk),
        .sys_rst (sys_rst),
        .pin     (link.sclk),
        .level   (sclk_s)
    );
    pin_sync #(.RST_VAL(1'b1)) u_cs (
        .clk     (clk),
        .sys_rst (sys_rst),
        .pin     (link.chip_select_n),
        .level   (cs_n_s)
    );
    pin_sync u_sdi (
        .clk     (clk),
        .sys_rst (sys_rst),
        .pin     (link.sdi),
        .level   (sdi_s)
    );
    pin_sync u_sleep (
        .clk     (clk),
        .sys_rst (sys_rst),
        .pin     (link.sleep_request_n),
        .level   (awake_s)
    );

    // select high or asleep: clock and data edges count for nothing
    wire active = awake_s && !cs_n_s && in_frame;
    wire sclk_rise = active && sclk_s && !sclk_d;
    wire sclk_fall = active && !sclk_s && sclk_d;
    wire cs_fall = awake_s && !cs_n_s && cs_n_d;
    wire cs_rise = awake_s && cs_n_s && !cs_n_d && in_frame;
    wire [2:0] bit_idx = fbits[2:0];
    wire [7:0] rx_byte = {rx_sr[6:0], sdi_s};
    wire byte_done = sclk_fall && bit_idx == 3'h7;
    wire [1:0] tag = rx_byte[7:6];
    wire is_status = tag == TAG_STATUS;
    wire is_header = tag == TAG_HEADER;
    // farthest device's bytes come first, so every device still holds
    // its data byte before the tail of the frame has passed it by
    wire [6:0] own_addr_idx = {1'b0, n_dev} - {1'b0, pos} - 7'h01;
    wire [6:0] own_data_idx = {1'b0, n_dev} + own_addr_idx;
    wire [6:0] n_plus = {1'b0, n_dev} + 7'h01;
    wire [FBITS_W-1:0] chain_bits = FBITS_W'(n_plus * STD_BITS);
    wire [FBITS_W-1:0] want_bits =
        chain ? chain_bits : FBITS_W'(STD_BITS);
    wire own_cmd_now = (phase == PH_FIRST && !rx_byte[CMD_TYPE_BIT]) ||
        (phase == PH_BODY && body_idx == own_addr_idx);
    // own command slot goes back as the report, all else passes through
    wire [7:0] next_tx =
        own_cmd_now ? mem[rx_byte[5:0]] : rx_byte;
    wire frame_ok = fbits == want_bits && have_cmd && have_data &&
        !sclk_bad && !sclk_s && (!chain || pos < n_dev);
    wire do_write = cs_rise && frame_ok && !cmd[CMD_RW_BIT];
    wire do_clear = cs_rise && frame_ok && chain && clr_req;
    wire frame_bad = cs_rise && !frame_ok;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sclk_d <= 1'b0;
            cs_n_d <= 1'b1;
        end else begin
            sclk_d <= sclk_s;
            cs_n_d <= cs_n_s;
        end
    end

    // framing and output pin
    always_ff @(posedge clk) begin
        if (sys_rst || !awake_s) begin
            in_frame <= 1'b0;
            sclk_bad <= 1'b0;
            fbits <= '0;
            rx_sr <= 8'h00;
            tx_byte <= 8'h00;
            link.sdo <= 1'b0;
            link.sdo_oe_n <= 1'b1;
        end else if (cs_fall) begin
            in_frame <= 1'b1;
            sclk_bad <= sclk_s;
            fbits <= '0;
            tx_byte <= {TAG_STATUS, faults};
            link.sdo_oe_n <= 1'b0;
        end else if (cs_rise) begin
            in_frame <= 1'b0;
            link.sdo_oe_n <= 1'b1;
        end else begin
            if (sclk_rise) begin
                link.sdo <= tx_byte[~bit_idx];
            end
            if (sclk_fall) begin
                rx_sr <= rx_byte;
                if (fbits != '1) begin
                    fbits <= fbits + FBITS_W'(1);
                end
            end
            if (byte_done) begin
                tx_byte <= next_tx;
            end
        end
    end

    // byte classification within the frame
    always_ff @(posedge clk) begin
        if (sys_rst || cs_fall) begin
            phase <= PH_FIRST;
            pos <= 6'h00;
            n_dev <= 6'h00;
            body_idx <= 7'h00;
            cmd <= 8'h00;
            data <= 8'h00;
            have_cmd <= 1'b0;
            have_data <= 1'b0;
            chain <= 1'b0;
            clr_req <= 1'b0;
        end else if (byte_done) begin
            unique case (phase)
                PH_FIRST: begin
                    if (!rx_byte[CMD_TYPE_BIT]) begin
                        cmd <= rx_byte;
                        have_cmd <= 1'b1;
                        phase <= PH_STD;
                    end else begin
                        chain <= 1'b1;
                        if (is_status) begin
                            pos <= 6'h01;
                            phase <= PH_STATUS;
                        end else if (is_header) begin
                            n_dev <= rx_byte[5:0];
                            phase <= PH_CHAIN_HEADER_SECOND;
                        end else begin
                            phase <= PH_DONE;
                        end
                    end
                end
                PH_STATUS: begin
                    if (is_status && pos != 6'h3f) begin
                        pos <= pos + 6'h01;
                    end else if (is_header) begin
                        n_dev <= rx_byte[5:0];
                        phase <= PH_CHAIN_HEADER_SECOND;
                    end else begin
                        phase <= PH_DONE;
                    end
                end
                PH_CHAIN_HEADER_SECOND: begin
                    clr_req <= rx_byte[HDR_CLR_BIT];
                    phase <= is_header ? PH_BODY : PH_DONE;
                end
                PH_BODY: begin
                    if (body_idx == own_addr_idx) begin
                        cmd <= rx_byte;
                        have_cmd <= 1'b1;
                    end
                    if (body_idx == own_data_idx) begin
                        data <= rx_byte;
                        have_data <= 1'b1;
                    end
                    if (body_idx != 7'h7f) begin
                        body_idx <= body_idx + 7'h01;
                    end
                end
                PH_STD: begin
                    data <= rx_byte;
                    have_data <= 1'b1;
                    phase <= PH_DONE;
                end
                PH_DONE: begin
                    phase <= PH_DONE;
                end
            endcase
        end
    end

    // fault latch and frame error: a new event beats a clear
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            faults <= FAULT_CLEAR;
            frame_error <= 1'b0;
        end else begin
            faults <= (do_clear ? FAULT_CLEAR : faults) | fault_in;
            frame_error <= frame_bad || (frame_error && !do_clear);
        end
    end

    // register store; a bad frame never reaches it
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            for (int i = 0; i < 64; i++) begin
                mem[i] <= 8'h00;
            end
            wr_valid <= 1'b0;
            wr_addr <= 6'h00;
            wr_data <= 8'h00;
        end else begin
            wr_valid <= do_write;
            if (do_write) begin
                mem[cmd[5:0]] <= data;
                wr_addr <= cmd[5:0];
                wr_data <= data;
            end
        end
    end
endmodule
`default_nettype wire

// File: hw/pin_sync.sv
// three-stage input synchroniser with agreement filter
`default_nettype none
module pin_sync #(
    parameter logic RST_VAL = 1'b0
) (
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic pin,
    output logic      level
);
    logic s1;
    logic s2;
    logic s3;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s1 <= RST_VAL;
            s2 <= RST_VAL;
            s3 <= RST_VAL;
            level <= RST_VAL;
        end else begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                level <= s3;
            end
        end
    end
endmodule
`default_nettype wire

// File: shared/motor_spi_if.sv
// serial link between the motor driver port and its controller
`default_nettype none
interface motor_spi_if;
    logic sclk;
    logic chip_select_n;
    logic sdi;
    logic sdo;
    logic sdo_oe_n;
    logic sleep_request_n;
    logic sdo_line;

    // released data output reads as pulled high
    assign sdo_line = sdo_oe_n ? 1'b1 : sdo;

    modport target (
        input  sclk,
        input  chip_select_n,
        input  sdi,
        input  sleep_request_n,
        output sdo,
        output sdo_oe_n
    );
    modport controller (
        output sclk,
        output chip_select_n,
        output sdi,
        output sleep_request_n,
        input  sdo_line
    );
endinterface
`default_nettype wire

// File: shared/motor_spi_pkg.sv
// shared constants for the motor driver serial port and its controller
`default_nettype none
package motor_spi_pkg;
    localparam int CLK_NS = 40;
    localparam int STD_BITS = 16;
    localparam int MAX_DEV = 63;
    localparam int MAX_BYTES = 2 + 2 * MAX_DEV;
    localparam int FBITS_W = 11;
    localparam int HBITS_W = 10;
    localparam int TICK_W = 5;
    // first two bits of chained status and header bytes
    localparam logic [1:0] TAG_STATUS = 2'h3;
    localparam logic [1:0] TAG_HEADER = 2'h2;
    localparam int CMD_TYPE_BIT = 7;
    localparam int CMD_RW_BIT = 6;
    localparam int HDR_CLR_BIT = 5;
    localparam logic [5:0] FAULT_CLEAR = 6'h00;
    // controller-made serial clock and frame spacing
    localparam int SCLK_HALF_NS = 600;
    localparam int SCLK_HALF_CYC = SCLK_HALF_NS / CLK_NS;
    localparam int CS_GAP_NS = 500;
    localparam int CS_GAP_CYC = (CS_GAP_NS + CLK_NS - 1) / CLK_NS;
    // controller register map, byte addresses
    localparam logic [10:0] OFS_CTRL = 11'h000;
    localparam logic [10:0] OFS_STATUS = 11'h004;
    localparam logic [10:0] OFS_SLEEP = 11'h008;
    localparam logic [1:0] REGION_TX = 2'h1;
    localparam logic [1:0] REGION_RX = 2'h2;
    localparam int CTRL_START_BIT = 8;
    localparam logic [7:0] LEN_RESET = 8'h02;
    localparam logic SLEEP_N_RESET = 1'b1;
endpackage
`default_nettype wire

// File: testbench/motor_spi_assertions.sv
// concurrent checks on the serial link between controller and target
`default_nettype none
module motor_spi_assertions
    import motor_spi_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic sclk,
    input wire logic chip_select_n,
    input wire logic sdi,
    input wire logic sdo,
    input wire logic sdo_oe_n,
    input wire logic sleep_request_n,
    input wire logic sdo_line
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    logic [7:0]  gap;
    logic [10:0] rises;
    logic        sclk_d;
    wire         sclk_up = sclk & ~sclk_d;

    // gap saturates so a long idle never wraps into a false short gap
    always_ff @(posedge clk) begin
        if (sys_rst) gap <= 8'hff;
        else if (!chip_select_n) gap <= 8'h00;
        else if (gap != 8'hff) gap <= gap + 8'h01;
    end
    always_ff @(posedge clk) begin
        sclk_d <= sclk;
        rises  <= chip_select_n ? 11'h000 : rises + {10'h000, sclk_up};
    end

    select_gap_a: assert property (
        $fell(chip_select_n) |-> gap >= CS_GAP_CYC)
        else $error("select high time between frames too short");
    clk_idle_a: assert property (chip_select_n |-> !sclk)
        else $error("serial clock moves while select is high");
    edge_low_a: assert property ($rose(chip_select_n) |-> !$past(sclk))
        else $error("serial clock high at select rise");
    whole_bytes_a: assert property ($rose(chip_select_n) |->
        rises[2:0] == 3'h0 && rises != 11'h000)
        else $error("frame does not hold whole bytes");
    clk_width_a: assert property ($rose(sclk) |=> sclk[*8])
        else $error("serial clock high phase too short");
    launch_rise_a: assert property ($changed(sdo) && !sdo_oe_n
        && !chip_select_n |-> sclk)
        else $error("output bit changed outside high clock phase");
    sdi_launch_a: assert property ($changed(sdi) && !$fell(chip_select_n)
        |-> $rose(sclk))
        else $error("controller data changed away from a clock rise");
    status_tag_a: assert property ($fell(sclk) && rises <= 11'h002
        |-> sdo_line)
        else $error("status byte top bits not high");
    idle_release_a: assert property (chip_select_n[*8] |-> sdo_oe_n)
        else $error("data output driven while deselected");
    sleep_off_a: assert property (!sleep_request_n[*8] |-> sdo_oe_n)
        else $error("data output driven while asleep");
    frame_drive_a: assert property ($fell(chip_select_n) && sleep_request_n
        && $past(sleep_request_n, 8) |-> ##[2:8] !sdo_oe_n)
        else $error("data output not driven in frame");
endmodule
`default_nettype wire

// File: testbench/motor_spi_target_port_bench.sv
// self-checking bench joining controller and target over the link
`default_nettype none
module motor_driver_spi_target_port_bench
    import motor_spi_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [10:0] address = 11'h000;
    logic        read = 1'b0;
    logic        write = 1'b0;
    logic [31:0] writedata = 32'h0000_0000;
    logic [31:0] readdata;
    logic        waitrequest;
    logic [5:0]  fault_in = 6'h00;
    logic [5:0]  faults;
    logic        frame_error;
    logic        wr_valid;
    logic [5:0]  wr_addr;
    logic [7:0]  wr_data;
    int          err_count = 0;
    int          compares = 0;
    int          wcount = 0;
    logic [7:0]  mem [64];
    logic [7:0]  tx [8];
    logic [7:0]  rx [8];
    logic [7:0]  rnd = 8'h18;
    logic [5:0]  acc = 6'h00;
    logic [31:0] q;

    motor_spi_if spi_link();
    motor_spi_target motor_spi_target_inst (.clk(clk), .sys_rst(sys_rst),
        .link(spi_link), .fault_in(fault_in), .faults(faults),
        .frame_error(frame_error), .wr_valid(wr_valid),
        .wr_addr(wr_addr), .wr_data(wr_data));
    motor_spi_controller motor_spi_controller_inst (.clk(clk),
        .sys_rst(sys_rst), .link(spi_link), .address(address),
        .read(read), .write(write), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest));
    motor_spi_assertions motor_spi_assertions_inst (.clk(clk),
        .sys_rst(sys_rst), .sclk(spi_link.sclk),
        .chip_select_n(spi_link.chip_select_n), .sdi(spi_link.sdi),
        .sdo(spi_link.sdo), .sdo_oe_n(spi_link.sdo_oe_n),
        .sleep_request_n(spi_link.sleep_request_n),
        .sdo_line(spi_link.sdo_line));

    initial forever #20 clk = ~clk;
    always @(posedge clk) if (wr_valid === 1'b1) wcount++;

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    function automatic logic [7:0] exp_status(input logic [5:0] f);
        return {2'b11, f};
    endfunction

    task automatic chk(input string nm, input logic [31:0] got, exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic close_out;
        if (err_count == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // request held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [10:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        @(posedge clk);
        address <= a;
        write <= wr;
        read <= ~wr;
        writedata <= d;
        do @(posedge clk); while (waitrequest !== 1'b0);
        r = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic run(input int n);
        for (int i = 0; i < n; i++) begin
            bus(1'b1, 11'h200 + 11'(i * 4), {24'h0, tx[i]}, q);
        end
        bus(1'b1, OFS_CTRL, 32'h0000_0100 | 32'(n), q);
        do bus(1'b0, OFS_STATUS, 32'h0, q); while (q[1] !== 1'b1);
        for (int i = 0; i < n; i++) begin
            bus(1'b0, 11'h400 + 11'(i * 4), 32'h0, q);
            rx[i] = q[7:0];
        end
    endtask

    task automatic std(input logic rw, input logic [5:0] a,
                       input logic [7:0] d);
        int w0;
        w0 = wcount;
        tx[0] = {1'b0, rw, a};
        tx[1] = d;
        run(2);
        chk("status", rx[0], exp_status(acc));
        chk("report", rx[1], mem[a]);
        chk("faults", faults, acc);
        chk("writes", wcount, w0 + (rw ? 0 : 1));
        if (!rw) begin
            mem[a] = d;
            chk("wr_addr", wr_addr, a);
            chk("wr_data", wr_data, d);
        end
    endtask

    initial begin
        int w0;
        foreach (mem[i]) mem[i] = 8'h00;
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (8) @(posedge clk);
        bus(1'b1, 11'h100, 32'h0000_00aa, q);
        bus(1'b0, 11'h100, 32'h0, q);
        chk("unmapped", q, 32'h0);
        std(1'b0, 6'h3f, 8'hff);
        std(1'b1, 6'h3f, 8'h00);
        for (int i = 0; i < 8; i++) begin
            if (i == 4) begin
                fault_in <= 6'h24;
                acc = acc | 6'h24;
                repeat (8) @(posedge clk);
            end
            rnd = lfsr(rnd);
            w0 = rnd[5:0];
            rnd = lfsr(rnd);
            std(1'b0, 6'(w0), rnd);
            std(1'b1, 6'(w0), 8'h00);
        end
        // 24 clocks: wrong count, write must be dropped
        w0 = wcount;
        tx[0] = {1'b0, 1'b0, 6'h05};
        tx[1] = 8'h5a;
        tx[2] = 8'h00;
        run(3);
        chk("frame_error", frame_error, 1'b1);
        chk("writes", wcount, w0);
        std(1'b1, 6'h05, 8'h00);
        // one-device chain with global clear in the second header
        fault_in <= 6'h00;
        repeat (8) @(posedge clk);
        tx = '{8'h81, 8'hb5, 8'h09, 8'hc3, 8'h00, 8'h00, 8'h00, 8'h00};
        run(4);
        chk("chain status", rx[0], exp_status(acc));
        chk("chain chain_header_first", rx[1], 8'h81);
        chk("chain chain_header_second", rx[2], 8'hb5);
        chk("chain report", rx[3], mem[9]);
        mem[9] = 8'hc3;
        acc = 6'h00;
        chk("faults", faults, 6'h00);
        chk("frame_error", frame_error, 1'b0);
        chk("wr_data", wr_data, 8'hc3);
        // last of two chained devices: its bytes come first in the body
        tx = '{8'hc0, 8'h82, 8'h8a, 8'h0a, 8'h4b, 8'h3c, 8'h00, 8'h00};
        run(6);
        chk("down status", rx[0], exp_status(acc));
        chk("down pass", rx[1], 8'hc0);
        chk("down chain_header_first", rx[2], 8'h82);
        chk("down chain_header_second", rx[3], 8'h8a);
        chk("down report", rx[4], mem[6'h0a]);
        chk("down other", rx[5], 8'h4b);
        chk("down data", wr_data, 8'h3c);
        chk("down addr", wr_addr, 6'h0a);
        chk("down error", frame_error, 1'b0);
        mem[6'h0a] = 8'h3c;
        // asleep: released line reads high and nothing commits
        bus(1'b1, OFS_SLEEP, 32'h0, q);
        repeat (10) @(posedge clk);
        w0 = wcount;
        tx[0] = {1'b0, 1'b0, 6'h09};
        tx[1] = 8'h11;
        run(2);
        chk("sleep status", rx[0], 8'hff);
        chk("writes", wcount, w0);
        bus(1'b1, OFS_SLEEP, 32'h1, q);
        repeat (10) @(posedge clk);
        std(1'b1, 6'h09, 8'h00);
        close_out();
    end

    initial begin
        repeat (60000) @(posedge clk);
        err_count++;
        close_out();
    end
endmodule
`default_nettype wire
